// >>> design/pig_glue.sv
`timescale 1ns/1ps
module pig_glue
    import pig_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    // Core internal bus
    input wire logic [19:0] mem_addr,
    input wire logic [7:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_hit,
    // External data bus drive
    output logic [7:0] ext_data_out,
    output logic ext_data_oe,
    // Chip selects
    output logic ram_select_n,
    output logic rom_select_n,
    // Ports
    input wire logic [7:0] port_one_in,
    output logic [7:0] port_one_out,
    output logic [7:0] port_one_oe,
    input wire logic [7:0] port_two_in,
    output logic [7:0] port_two_out,
    output logic [7:0] port_two_oe,
    // Counter/timer pin side
    input wire logic [3:0] ct_zero_count,
    output logic [3:0] ct_trigger,
    output logic ct_sel,
    input wire logic [7:0] ct_rdata,
    // Serial controller hookup
    output logic ser_sel,
    output logic ser_data_sel,
    input wire logic [7:0] ser_rdata,
    input wire logic ser_int_n,
    output logic ser_rst_n,
    output logic irq_line_zero_oe,
    input wire logic int_ack,
    output logic wait_n,
    input wire logic vector_includes_status,
    input wire logic [7:0] vec_raw,
    input wire logic [7:0] vec_status,
    input wire logic [2:0] ip_bits,
    input wire logic rd_vector,
    input wire logic rd_pending,
    input wire logic mc_write,
    input wire logic [1:0] mc_reset_cmd,
    output logic chan_reset,
    output logic [7:0] vec_readback,
    output logic [7:0] pend_readback
);
    // ----------------------------------------
    // Registers and decode
    // ----------------------------------------
    logic [7:0] ram_upper_boundary_q; // Top of RAM
    logic [7:0] ram_lower_boundary_q; // Bottom of RAM
    logic [7:0] rom_upper_boundary_q; // Top of ROM
    logic [7:0] system_configuration_q; // Mode bits
    logic [7:0] p1_dir, p1_rd, p1_pout, p1_poe;
    logic [7:0] p2_dir, p2_rd;
    logic [7:0] p1_pin_mix;
    logic [1:0] wait_cnt_q; // Ack wait counter
    logic ack_q; // Ack seen last cycle
    logic periph_hit; // Peripheral register hit

    // Full address compare
    function automatic logic pig_is(input logic [7:0] a, input logic [7:0] r);
        pig_is = (a == r);
    endfunction

    assign ct_sel = (io_addr >= PIG_ADDR_CT_LO) && (io_addr <= PIG_ADDR_CT_HI) && (io_rd || io_wr);
    assign ser_sel = (pig_is(io_addr, PIG_ADDR_SER_CTRL) || pig_is(io_addr, PIG_ADDR_SER_DATA))
        && (io_rd || io_wr);
    assign ser_data_sel = pig_is(io_addr, PIG_ADDR_SER_DATA);
    // 14 peripheral registers beside 64 core ones
    assign periph_hit = (io_addr >= PIG_ADDR_P1_DIR) && (io_addr <= PIG_ADDR_SYS_CFG);
    assign io_hit = periph_hit && (io_rd || io_wr);

    // ----------------------------------------
    // Boundary and configuration registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ram_upper_boundary_q <= PIG_RST_RAM_UPPER;
            ram_lower_boundary_q <= PIG_RST_RAM_LOWER;
            rom_upper_boundary_q <= PIG_RST_ROM_UPPER;
        end else if (io_wr) begin
            // Writes land on the cycle-end edge
            if (pig_is(io_addr, PIG_ADDR_RAM_UPPER)) begin
                ram_upper_boundary_q <= io_wdata;
            end
            if (pig_is(io_addr, PIG_ADDR_RAM_LOWER)) begin
                ram_lower_boundary_q <= io_wdata;
            end
            if (pig_is(io_addr, PIG_ADDR_ROM_UPPER)) begin
                rom_upper_boundary_q <= io_wdata;
            end
        end
    end
    // Configuration register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            system_configuration_q <= PIG_RST_SYS_CFG;
        end else if (io_wr && pig_is(io_addr, PIG_ADDR_SYS_CFG)) begin
            system_configuration_q <= io_wdata;
        end
    end

    // ----------------------------------------
    // Chip selects
    // ----------------------------------------
    pig_chip_select u_cs (
        .mem_addr_hi(mem_addr[19:12]),
        .ram_upper(ram_upper_boundary_q),
        .ram_lower(ram_lower_boundary_q),
        .rom_upper(rom_upper_boundary_q),
        .rom_off(system_configuration_q[PIG_CFG_ROM_OFF]),
        .ram_select_n(ram_select_n),
        .rom_select_n(rom_select_n)
    );

    // ----------------------------------------
    // Parallel ports
    // ----------------------------------------
    pig_port #(.WIDTH(8)) u_p1 (
        .core_clk(core_clk),
        .srst(srst),
        .dir_we(io_wr && pig_is(io_addr, PIG_ADDR_P1_DIR)),
        .data_we(io_wr && pig_is(io_addr, PIG_ADDR_P1_DATA)),
        .wdata(io_wdata),
        .pin_in(p1_pin_mix),
        .pin_out(p1_pout),
        .pin_oe(p1_poe),
        .dir_q(p1_dir),
        .read_data(p1_rd)
    );
    pig_port #(.WIDTH(8)) u_p2 (
        .core_clk(core_clk),
        .srst(srst),
        .dir_we(io_wr && pig_is(io_addr, PIG_ADDR_P2_DIR)),
        .data_we(io_wr && pig_is(io_addr, PIG_ADDR_P2_DATA)),
        .wdata(io_wdata),
        .pin_in(port_two_in),
        .pin_out(port_two_out),
        .pin_oe(port_two_oe),
        .dir_q(p2_dir),
        .read_data(p2_rd)
    );
    assign p1_pin_mix = port_one_in;

    // Timer mode: low nibble triggers in, high nibble zero-count out
    always_comb begin
        if (system_configuration_q[PIG_CFG_TIMER_PINS]) begin
            port_one_out = {ct_zero_count, 4'h0};
            port_one_oe = 8'hF0;
            ct_trigger = port_one_in[3:0];
        end else begin
            port_one_out = p1_pout;
            port_one_oe = p1_poe;
            ct_trigger = 4'h0;
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        io_rdata = 8'h00;
        case (io_addr)
            PIG_ADDR_P1_DIR: io_rdata = p1_dir;
            PIG_ADDR_P1_DATA: io_rdata = p1_rd;
            PIG_ADDR_P2_DIR: io_rdata = p2_dir;
            PIG_ADDR_P2_DATA: io_rdata = p2_rd;
            PIG_ADDR_SER_CTRL: io_rdata = ser_rdata;
            PIG_ADDR_SER_DATA: io_rdata = ser_rdata;
            PIG_ADDR_RAM_UPPER: io_rdata = ram_upper_boundary_q;
            PIG_ADDR_RAM_LOWER: io_rdata = ram_lower_boundary_q;
            PIG_ADDR_ROM_UPPER: io_rdata = rom_upper_boundary_q;
            PIG_ADDR_SYS_CFG: io_rdata = system_configuration_q;
            default: begin
                if (ct_sel) begin
                    io_rdata = ct_rdata;
                end
            end
        endcase
    end

    // External bus visibility of peripheral reads
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ext_data_out <= 8'h00;
            ext_data_oe <= 1'b0;
        end else begin
            ext_data_out <= io_rdata;
            ext_data_oe <= io_rd && periph_hit && system_configuration_q[PIG_CFG_EMULATOR];
        end
    end

    // ----------------------------------------
    // Serial controller hookup
    // ----------------------------------------
    assign ser_rst_n = !srst;
    assign irq_line_zero_oe = !ser_int_n;
    // Second-channel reset ignored, hardware reset passes
    assign chan_reset = mc_write && (mc_reset_cmd == 2'h2 || mc_reset_cmd == 2'h3);
    // Vector and pending readback
    always_ff @(posedge core_clk) begin
        if (srst) begin
            vec_readback <= 8'h00;
            pend_readback <= 8'h00;
        end else begin
            if (rd_vector) begin
                vec_readback <= vector_includes_status ? vec_status : vec_raw;
            end
            if (rd_pending) begin
                pend_readback <= {2'h0, ip_bits, 3'h0};
            end
        end
    end

    // Acknowledge wait-state generator
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wait_cnt_q <= 2'h0;
            ack_q <= 1'b0;
        end else begin
            ack_q <= int_ack;
            if (int_ack && !ack_q) begin
                wait_cnt_q <= PIG_ACK_WAIT_CNT;
            end else if (wait_cnt_q != 2'h0) begin
                wait_cnt_q <= wait_cnt_q - 2'h1;
            end
        end
    end
    assign wait_n = !((int_ack && !ack_q) || wait_cnt_q != 2'h0);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_ROM_OFF: assert property (@(posedge core_clk) disable iff (srst)
        system_configuration_q[PIG_CFG_ROM_OFF] |-> rom_select_n)
        else $error("rom select active while disabled");
    AST_ROM_CMP: assert property (@(posedge core_clk) disable iff (srst)
        (!system_configuration_q[PIG_CFG_ROM_OFF] && mem_addr[19:12] <= rom_upper_boundary_q)
        |-> !rom_select_n)
        else $error("rom select missing at or below boundary");
    AST_EMU_OFF: assert property (@(posedge core_clk) disable iff (srst)
        !$past(system_configuration_q[PIG_CFG_EMULATOR]) |-> !ext_data_oe)
        else $error("external bus driven outside emulator mode");
    AST_EMU_ON: assert property (@(posedge core_clk) disable iff (srst)
        (io_rd && periph_hit && system_configuration_q[PIG_CFG_EMULATOR]) |=> ext_data_oe)
        else $error("emulator read not driven");
    AST_WAIT2: assert property (@(posedge core_clk) disable iff (srst)
        (int_ack && !ack_q) |-> !wait_n [*3] ##1 wait_n)
        else $error("acknowledge wait length wrong");
    AST_RESET_IN: assert property (@(posedge core_clk)
        $past(srst) |-> (port_one_oe == 8'h00 && port_two_oe == 8'h00))
        else $error("port pin driven after reset");
    AST_CFG_WR: assert property (@(posedge core_clk) disable iff (srst)
        (io_wr && io_addr == PIG_ADDR_SYS_CFG) |=> system_configuration_q == $past(io_wdata))
        else $error("configuration write lost");
    AST_ALIAS: assert property (@(posedge core_clk) disable iff (srst)
        (io_addr < PIG_ADDR_P1_DIR) |-> (io_rdata == 8'h00 && !io_hit))
        else $error("peripheral register aliased");
    AST_TIMER_PINS: assert property (@(posedge core_clk) disable iff (srst)
        system_configuration_q[PIG_CFG_TIMER_PINS] |-> port_one_oe == 8'hF0)
        else $error("timer pins not overriding port");
    COV_ROM_OFF: cover property (@(posedge core_clk) system_configuration_q[PIG_CFG_ROM_OFF]);
    COV_EMU: cover property (@(posedge core_clk) ext_data_oe);
    COV_ACK: cover property (@(posedge core_clk) int_ack && !ack_q);
endmodule

// >>> design/pig_pkg.sv
// Function
// - Chip select low when address at or below boundary
// - Decode A19-A12 only, no bus qualification
// - Boundary registers at EAh, EBh, ECh
// - Configuration D5 set disables ROM select
// - Emulator mode drives peripheral read data out
// - Otherwise external data bus stays undriven
// - Configuration D1 selects emulator mode
// - Two ports with data and direction registers
// - Timer pin function overrides first port
// - Configuration D0 selects timer pin function
// - All port pins inputs after reset
// - Full A7-A0 decode, no aliases
// - Peripheral register set completes 78 registers
// - Two wait states on serial acknowledge
// - Serial unit reset and interrupt hookup
// - Vector readback modified when status bit set
// - Pending readback shows single channel status
// - Second-channel software reset is ignored
// - Port registers at E0h-E3h, direction first
// - Serial control E8h, data E9h
package pig_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] PIG_ADDR_P1_DIR = 8'hE0;
    localparam logic [7:0] PIG_ADDR_P1_DATA = 8'hE1;
    localparam logic [7:0] PIG_ADDR_P2_DIR = 8'hE2;
    localparam logic [7:0] PIG_ADDR_P2_DATA = 8'hE3;
    localparam logic [7:0] PIG_ADDR_CT_LO = 8'hE4;
    localparam logic [7:0] PIG_ADDR_CT_HI = 8'hE7;
    localparam logic [7:0] PIG_ADDR_SER_CTRL = 8'hE8;
    localparam logic [7:0] PIG_ADDR_SER_DATA = 8'hE9;
    localparam logic [7:0] PIG_ADDR_RAM_UPPER = 8'hEA;
    localparam logic [7:0] PIG_ADDR_RAM_LOWER = 8'hEB;
    localparam logic [7:0] PIG_ADDR_ROM_UPPER = 8'hEC;
    localparam logic [7:0] PIG_ADDR_SYS_CFG = 8'hED;
    // ----------------------------------------
    // Configuration fields
    // ----------------------------------------
    localparam int PIG_CFG_TIMER_PINS = 0;
    localparam int PIG_CFG_EMULATOR = 1;
    localparam int PIG_CFG_ROM_OFF = 5;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] PIG_RST_RAM_UPPER = 8'hFF;
    localparam logic [7:0] PIG_RST_RAM_LOWER = 8'hFF;
    localparam logic [7:0] PIG_RST_ROM_UPPER = 8'h00;
    localparam logic [7:0] PIG_RST_SYS_CFG = 8'h00;
    localparam logic [7:0] PIG_RST_DIR = 8'h00;
    localparam logic [7:0] PIG_RST_DATA = 8'h00;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int PIG_ACK_WAIT_CYCLES = 2;
    localparam logic [1:0] PIG_ACK_WAIT_CNT = 2'h2;
endpackage

// >>> design/pig_chip_select.sv
`timescale 1ns/1ps
module pig_chip_select
    import pig_pkg::*;
(
    input wire logic [7:0] mem_addr_hi,
    input wire logic [7:0] ram_upper,
    input wire logic [7:0] ram_lower,
    input wire logic [7:0] rom_upper,
    input wire logic rom_off,
    output logic ram_select_n,
    output logic rom_select_n
);
    // ----------------------------------------
    // Address compare, no strobe gating
    // ----------------------------------------
    // RAM window above ROM boundary up to upper boundary
    always_comb begin
        ram_select_n = 1'b1;
        rom_select_n = 1'b1;
        if (mem_addr_hi <= rom_upper && !rom_off) begin
            rom_select_n = 1'b0;
        end
        // RAM also starts above the lower boundary; lower boundary FFh or ROM off drops the bottom limit
        if (mem_addr_hi <= ram_upper && (mem_addr_hi > ram_lower || ram_lower == 8'hFF ||
                mem_addr_hi > rom_upper || rom_off)) begin
            ram_select_n = 1'b0;
        end
    end
endmodule

// >>> design/pig_port.sv
`timescale 1ns/1ps
module pig_port
    import pig_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic dir_we,
    input wire logic data_we,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] dir_q,
    output logic [WIDTH-1:0] read_data
);
    logic [WIDTH-1:0] data_q; // Output latch
    // ----------------------------------------
    // Direction register
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dir_q <= WIDTH'(PIG_RST_DIR);
        end else if (dir_we) begin
            dir_q <= wdata;
        end
    end
    // Data register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            data_q <= WIDTH'(PIG_RST_DATA);
        end else if (data_we) begin
            data_q <= wdata;
        end
    end
    // Per-bit pin drive and read mix
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        assign pin_out[i] = data_q[i];
        assign pin_oe[i] = dir_q[i];
        assign read_data[i] = dir_q[i] ? data_q[i] : pin_in[i];
    end
endmodule

// >>> verification/pig_core_model.sv
`timescale 1ns/1ps
// -----------------------------------------
// Core side of the internal I/O bus
// -----------------------------------------
module pig_core_model (
    input wire logic core_clk,
    input wire logic [7:0] io_rdata,
    input wire logic io_hit,
    output logic [19:0] mem_addr,
    output logic [7:0] io_addr,
    output logic io_rd,
    output logic io_wr,
    output logic [7:0] io_wdata
);
    // Bus idle at time zero
    initial begin
        mem_addr = 20'h00000;
        io_addr = 8'h00;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_wdata = 8'h00;
    end
    // Write held up to the edge that takes it; core block never placed at C0h-FFh
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0;
        io_wdata <= ~d;
    endtask
    // Read: data and hit taken at the closing edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge core_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge core_clk);
        d = io_rdata;
        h = io_hit;
        io_rd <= 1'b0;
    endtask
    // Upper address only, no strobe goes with it
    task automatic mem(input logic [7:0] hi);
        @(posedge core_clk);
        mem_addr <= {hi, 12'hABC};
    endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import pig_pkg::*;
;
    // -----------------------------------------
    // Signals
    // -----------------------------------------
    logic core_clk = 1'b0, srst = 1'b1;
    logic [19:0] mem_addr;
    logic [7:0] io_addr, io_wdata, io_rdata, ext_data_out, port_one_in, port_one_out, port_one_oe;
    logic [7:0] port_two_in, port_two_out, port_two_oe, vec_readback, pend_readback, rdv;
    logic [7:0] ext1 = 8'h3C, ext2 = 8'hC3, ct_rdata = 8'h77, ser_rdata = 8'h5C;
    logic [7:0] vec_raw = 8'h40, vec_status = 8'h4E;
    logic io_rd, io_wr, io_hit, ext_data_oe, ram_select_n, rom_select_n, ct_sel, ser_sel, ser_data_sel;
    logic ser_rst_n, irq_line_zero_oe, wait_n, chan_reset, hit;
    logic ser_int_n = 1'b1, int_ack = 1'b0, vector_includes_status = 1'b0;
    logic rd_vector = 1'b0, rd_pending = 1'b0, mc_write = 1'b0;
    logic [3:0] ct_zero_count = 4'h0, ct_trigger;
    logic [2:0] ip_bits = 3'h5;
    logic [1:0] mc_reset_cmd = 2'h0;
    int failures = 0, checked = 0, cycles = 0;
    // Select table rows: address, boundaries, ROM off, expected selects
    typedef struct packed {
        logic [7:0] a, ru, rl, ro;
        logic off, ram_n, rom_n;
    } pig_tb_row_t;
    pig_tb_row_t rows [6] = '{'{8'h10, 8'h7F, 8'h1F, 8'h1F, 1'b0, 1'b1, 1'b0},
        '{8'h1F, 8'h7F, 8'h1F, 8'h1F, 1'b0, 1'b1, 1'b0}, '{8'h20, 8'h7F, 8'h1F, 8'h1F, 1'b0, 1'b0, 1'b1},
        '{8'h7F, 8'h7F, 8'h1F, 8'h1F, 1'b0, 1'b0, 1'b1}, '{8'h80, 8'h7F, 8'h1F, 8'h1F, 1'b0, 1'b1, 1'b1},
        '{8'h10, 8'h7F, 8'h1F, 8'h1F, 1'b1, 1'b0, 1'b1}};
    logic [7:0] rst_tab [4] = '{PIG_RST_RAM_UPPER, PIG_RST_RAM_LOWER, PIG_RST_ROM_UPPER, PIG_RST_SYS_CFG};
    // Pin level: own drive where enabled, outside drive elsewhere
    assign port_one_in = (port_one_out & port_one_oe) | (ext1 & ~port_one_oe);
    assign port_two_in = (port_two_out & port_two_oe) | (ext2 & ~port_two_oe);
    // Clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end
    pig_core_model i_core (.core_clk, .io_rdata, .io_hit, .mem_addr, .io_addr, .io_rd, .io_wr, .io_wdata);
    pig_glue i_dut (.core_clk, .srst, .mem_addr, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_hit,
        .ext_data_out, .ext_data_oe, .ram_select_n, .rom_select_n, .port_one_in, .port_one_out, .port_one_oe,
        .port_two_in, .port_two_out, .port_two_oe, .ct_zero_count, .ct_trigger, .ct_sel, .ct_rdata, .ser_sel,
        .ser_data_sel, .ser_rdata, .ser_int_n, .ser_rst_n, .irq_line_zero_oe, .int_ack, .wait_n,
        .vector_includes_status, .vec_raw, .vec_status, .ip_bits, .rd_vector, .rd_pending, .mc_write,
        .mc_reset_cmd, .chan_reset, .vec_readback, .pend_readback);
    // -----------------------------------------
    // Compare and close
    // -----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Read with both selects looked at while the strobe still stands
    task automatic rd_sel(input logic [7:0] a, input logic [7:0] exp_ser, input logic [7:0] exp_ct);
        fork
            i_core.rd(a, rdv, hit);
            begin
                @(posedge core_clk);
                #1;
                chk("ser_sel", exp_ser, 8'(ser_sel));
                chk("ct_sel", exp_ct, 8'(ct_sel));
            end
        join
    endtask
    // -----------------------------------------
    // Main sequence
    // -----------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        #1;
        chk("ser_rst_n in reset", 8'h00, 8'(ser_rst_n));
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        chk("ser_rst_n", 8'h01, 8'(ser_rst_n));
        chk("port_one_oe", 8'h00, port_one_oe);
        chk("port_two_oe", 8'h00, port_two_oe);
        chk("wait_n idle", 8'h01, 8'(wait_n));
        chk("rom_select_n at zero", 8'h00, 8'(rom_select_n));
        for (int i = 0; i < 4; i++) begin
            i_core.rd(PIG_ADDR_RAM_UPPER + 8'(i), rdv, hit);
            chk("reset value", rst_tab[i], rdv);
        end
        $display("test reset done");
        // Boundaries are always rewritten before ROM select goes off
        foreach (rows[i]) begin
            i_core.wr(PIG_ADDR_RAM_UPPER, rows[i].ru);
            i_core.wr(PIG_ADDR_RAM_LOWER, rows[i].rl);
            i_core.wr(PIG_ADDR_ROM_UPPER, rows[i].ro);
            i_core.wr(PIG_ADDR_SYS_CFG, rows[i].off ? 8'h20 : 8'h00);
            i_core.mem(rows[i].a);
            #1;
            chk("ram_select_n", 8'(rows[i].ram_n), 8'(ram_select_n));
            chk("rom_select_n", 8'(rows[i].rom_n), 8'(rom_select_n));
            i_core.rd(PIG_ADDR_ROM_UPPER, rdv, hit);
            chk("rom_upper readback", rows[i].ro, rdv);
        end
        $display("test select table done");
        // Ports: mixed directions, pins read back
        i_core.wr(PIG_ADDR_P1_DIR, 8'h0F);
        i_core.wr(PIG_ADDR_P1_DATA, 8'hA5);
        i_core.wr(PIG_ADDR_P2_DIR, 8'hF0);
        i_core.wr(PIG_ADDR_P2_DATA, 8'h5A);
        #1;
        chk("port_one_oe", 8'h0F, port_one_oe);
        chk("port_two_oe", 8'hF0, port_two_oe);
        chk("port_one_out", 8'h05, port_one_out & 8'h0F);
        i_core.rd(PIG_ADDR_P1_DATA, rdv, hit);
        chk("port one pins", 8'h35, rdv);
        i_core.rd(PIG_ADDR_P2_DATA, rdv, hit);
        chk("port two pins", 8'h53, rdv);
        i_core.rd(PIG_ADDR_P1_DIR, rdv, hit);
        chk("port one dir", 8'h0F, rdv);
        // Timer pin function overrides port one
        i_core.wr(PIG_ADDR_SYS_CFG, 8'h01);
        ct_zero_count <= 4'h9;
        #1;
        chk("timer pin oe", 8'hF0, port_one_oe);
        chk("zero count out", 8'h90, port_one_out & 8'hF0);
        chk("trigger in", 8'h0C, 8'(ct_trigger));
        i_core.wr(PIG_ADDR_SYS_CFG, 8'h00);
        #1;
        chk("port oe back", 8'h0F, port_one_oe);
        $display("test ports done");
        // Aliases and reserved places stay silent
        i_core.rd(8'h6A, rdv, hit);
        chk("alias read", 8'h00, rdv);
        chk("alias hit", 8'h00, 8'(hit));
        i_core.wr(8'h6D, 8'h02);
        i_core.rd(PIG_ADDR_SYS_CFG, rdv, hit);
        chk("cfg after alias write", 8'h00, rdv);
        chk("cfg hit", 8'h01, 8'(hit));
        i_core.rd(8'hEE, rdv, hit);
        chk("reserved read", 8'h00, rdv);
        // Emulator mode: one cycle of drive per peripheral read
        i_core.wr(PIG_ADDR_SYS_CFG, 8'h02);
        i_core.rd(PIG_ADDR_RAM_UPPER, rdv, hit);
        #1;
        chk("emulator oe", 8'h01, 8'(ext_data_oe));
        chk("emulator data", rows[5].ru, ext_data_out);
        i_core.rd(8'h10, rdv, hit);
        #1;
        chk("core read not driven", 8'h00, 8'(ext_data_oe));
        i_core.wr(PIG_ADDR_SYS_CFG, 8'h00);
        i_core.rd(PIG_ADDR_RAM_UPPER, rdv, hit);
        #1;
        chk("normal mode oe", 8'h00, 8'(ext_data_oe));
        $display("test decode and emulator done");
        // Serial and timer hookup
        i_core.rd(PIG_ADDR_SER_DATA, rdv, hit);
        chk("serial data read", ser_rdata, rdv);
        #1;
        chk("data port select", 8'h01, 8'(ser_data_sel));
        i_core.rd(PIG_ADDR_CT_LO, rdv, hit);
        chk("timer read", ct_rdata, rdv);
        rd_sel(PIG_ADDR_SER_CTRL, 8'h01, 8'h00);
        chk("serial control read", ser_rdata, rdv);
        rd_sel(PIG_ADDR_CT_HI, 8'h00, 8'h01);
        chk("timer top read", ct_rdata, rdv);
        ser_int_n <= 1'b0;
        int_ack <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            #1;
            chk("irq drive", 8'h01, 8'(irq_line_zero_oe));
            chk("wait_n", (i < 3) ? 8'h00 : 8'h01, 8'(wait_n));
            @(posedge core_clk);
        end
        int_ack <= 1'b0;
        ser_int_n <= 1'b1;
        vector_includes_status <= 1'b1;
        rd_vector <= 1'b1;
        rd_pending <= 1'b1;
        @(posedge core_clk);
        vector_includes_status <= 1'b0;
        rd_pending <= 1'b0;
        #1;
        chk("irq released", 8'h00, 8'(irq_line_zero_oe));
        chk("vector with status", vec_status, vec_readback);
        chk("pending", 8'h28, pend_readback);
        @(posedge core_clk);
        rd_vector <= 1'b0;
        #1;
        chk("plain vector", vec_raw, vec_readback);
        for (int c = 0; c < 4; c++) begin
            @(posedge core_clk);
            mc_write <= 1'b1;
            mc_reset_cmd <= 2'(c);
            #1;
            chk("chan_reset", (c >= 2) ? 8'h01 : 8'h00, 8'(chan_reset));
        end
        @(posedge core_clk);
        mc_write <= 1'b0;
        $display("test serial done");
        // Mid-run reset returns registers and pins to defaults
        srst <= 1'b1;
        @(posedge core_clk);
        srst <= 1'b0;
        #1;
        chk("port_one_oe after reset", 8'h00, port_one_oe);
        chk("ext_data_oe after reset", 8'h00, 8'(ext_data_oe));
        i_core.rd(PIG_ADDR_RAM_UPPER, rdv, hit);
        chk("ram_upper after reset", PIG_RST_RAM_UPPER, rdv);
        i_core.rd(PIG_ADDR_P1_DIR, rdv, hit);
        chk("port one dir after reset", PIG_RST_DIR, rdv);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule
